// ===== aodr_chan_diag.sv
// Per-channel error detail byte and channel indicator.
// Assumes error inputs are synchronous levels from the output stage.
module aodr_chan_diag (
    input wire logic clk_in, // System clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic cfg_err_in, // Channel configuration error
    input wire logic short_in, // Short or overload seen
    input wire logic short_en_in, // Short detection enabled
    output logic [7:0] detail_out, // Channel detail byte
    output logic led_out // Channel indicator, high lit
);
    logic short_seen;
    logic any_err;

    // Shorts count only where detection is enabled
    assign short_seen = short_in & short_en_in;
    assign any_err = short_seen | cfg_err_in;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            detail_out <= 8'h00;
            led_out <= 1'b0;
        end else begin
            detail_out <= 8'h00;
            detail_out[aodr_pkg::DET_CFG] <= cfg_err_in;
            detail_out[aodr_pkg::DET_SHORT] <= short_seen;
            led_out <= any_err;
        end
    end
endmodule : aodr_chan_diag

// ===== aodr_coupler_model.sv
// Coupler model: issues one read at a time and gathers the answer bytes.
// Assumes the record answers within 40 cycles of taking a request.
module aodr_coupler_model (
    input wire logic clk_in, // System clock
    input wire logic ready_in, // Record idle
    input wire logic rsp_valid_in, // Answer byte valid
    input wire logic [7:0] rsp_data_in, // Answer byte
    input wire logic rsp_last_in, // Last answer byte
    input wire logic rsp_err_in, // Refused request
    output logic valid_out, // Request strobe
    output logic [1:0] path_out, // Access path
    output logic [7:0] rn_out, // Record number
    output logic [15:0] ix_out, // Object index
    output logic [7:0] sx_out // Object subindex
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got [0:19];
    int cnt;
    logic err;
    int cyc = 0;
    int take_cyc;
    initial begin
        valid_out = 1'b0;
        {path_out, rn_out, ix_out, sx_out} = 34'h0;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    // Held until taken; fields inverted after, so stale values never look valid
    task automatic rd(input logic [1:0] p, input logic [7:0] rn, input logic [15:0] ix,
            input logic [7:0] sx);
        @(posedge clk_in);
        #1;
        cnt = 0;
        err = 1'b0;
        valid_out = 1'b1;
        {path_out, rn_out, ix_out, sx_out} = {p, rn, ix, sx};
        do @(posedge clk_in); while (ready_in !== 1'b1);
        take_cyc = cyc;
        #1;
        valid_out = 1'b0;
        {path_out, rn_out, ix_out, sx_out} = ~{p, rn, ix, sx};
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_in);
            if (rsp_valid_in === 1'b1 && cnt < 20) begin
                got[cnt] = rsp_data_in;
                err = rsp_err_in;
                cnt++;
                if (rsp_last_in === 1'b1) break;
            end
        end
    endtask : rd
endmodule : aodr_coupler_model

// ===== aodr_diag_checker.sv
// Port-level checks of the diagnostic record's answer timing and content.
// Assumes it is bound to aodr_diag_record; one clock domain only.
module aodr_diag_checker (
    input wire logic clk_in, // System clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic req_valid_in, // Request strobe
    input wire logic [1:0] req_path_in, // Access path
    input wire logic [7:0] req_record_number_in, // Record number
    input wire logic [15:0] req_object_index_in, // Object index
    input wire logic req_ready_out, // Record idle
    input wire logic rsp_valid_out, // Answer byte valid
    input wire logic [7:0] rsp_data_out, // Answer byte
    input wire logic rsp_last_out, // Last answer byte
    input wire logic rsp_err_out, // Refused request
    input wire logic [3:0] chan_cfg_err_in, // Config errors
    input wire logic [3:0] chan_short_in, // Shorts seen
    input wire logic [3:0] short_enable_in, // Short detection enables
    input wire logic [3:0] chan_led_out // Channel indicators
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire take = req_valid_in && req_ready_out;
    wire take_rec = take && req_path_in == 2'h0;
    wire take_full = take_rec && req_record_number_in == 8'h01;
    wire take_short = take_rec && req_record_number_in == 8'h00;
    wire take_ix = take && req_path_in == 2'h1 && req_object_index_in == 16'h2f01;

    a_led_follow: assert property ($past(rst_b_in) |-> chan_led_out ==
        ($past(chan_cfg_err_in) | ($past(chan_short_in) & $past(short_enable_in))))
        else $error("indicator does not follow channel errors");
    a_answer_delay: assert property (take |-> ##2 rsp_valid_out)
        else $error("answer not two cycles after request");
    a_busy_after: assert property (take |=> !req_ready_out)
        else $error("ready stays high after request");
    a_full_length: assert property (take_full |-> ##2
        (rsp_valid_out && !rsp_last_out) [*8] ##12 (rsp_valid_out && rsp_last_out))
        else $error("full record length wrong");
    a_short_length: assert property (take_short |-> ##2
        (rsp_valid_out && !rsp_last_out) [*3] ##1 (rsp_valid_out && rsp_last_out))
        else $error("short record length wrong");
    a_index_full: assert property (take_ix |-> ##21 (rsp_last_out && !rsp_err_out))
        else $error("index record length wrong");
    a_modinfo_byte: assert property (take_full |-> ##3 rsp_data_out == 8'h15)
        else $error("module information byte wrong");
    a_refuse_byte: assert property (rsp_err_out |-> rsp_valid_out && rsp_last_out
        && rsp_data_out == 8'h00) else $error("refusal answer malformed");
    a_path_refused: assert property (take && req_path_in == 2'h3 |->
        ##2 rsp_err_out) else $error("unknown path not refused");
    a_idle_quiet: assert property (!rsp_valid_out |->
        rsp_data_out == 8'h00 && !rsp_last_out) else $error("answer lines active while idle");
    cover property (take_full ##21 rsp_last_out);
    cover property (rsp_err_out);
    cover property (chan_led_out != 4'h0);
endmodule : aodr_diag_checker

// ===== aodr_diag_record.sv
// Diagnostic record of a four-channel analog output module, read byte by byte.
// Assumes the coupler issues one request at a time and accepts every answer byte.
// Error inputs are synchronous levels; the record follows them one cycle later.

// How it works
// - No interrupt output; diagnostics leave as bytes the coupler reads and on the channel indicators.
// - An error lights its channel indicator and shows in the record.
// - Config errors always reported; shorts only where detection is enabled.
// - Record number 01h returns whole record, 00h only first four bytes.
// - Object index 2F01h returns whole record, 2F00h only first four bytes.
// - Index 5005h: subindex 02h general byte up to 13h ticker.
// - General byte: failure, internal, external, channel, aux supply, parameter bits.
// - Module information byte reads class 0101b with channel-info bit set.
// - Constant byte gives eight diagnostic bits per channel.
// - Constant byte gives four channels.
// - One detail byte per channel, reset zero, then four reserved bytes.
module aodr_diag_record (
    input wire logic clk_in, // System clock, 200 MHz
    input wire logic rst_b_in, // Async reset, active low
    input wire logic req_valid_in, // Read request strobe
    input wire logic [1:0] req_path_in, // Access path code
    input wire logic [7:0] req_record_number_in, // Record number
    input wire logic [15:0] req_object_index_in, // Object index
    input wire logic [7:0] req_object_subindex_in, // Object subindex
    output logic req_ready_out, // Request can be taken
    output logic rsp_valid_out, // Answer byte valid
    output logic [7:0] rsp_data_out, // Answer byte
    output logic rsp_last_out, // Last byte of answer
    output logic rsp_err_out, // Request not mapped
    input wire logic module_fail_in, // Module failure
    input wire logic internal_err_in, // Internal error
    input wire logic aux_supply_missing_in, // Aux supply missing
    input wire logic param_err_in, // Module parameter error
    input wire logic diag_overflow_in, // Diag buffer overflow
    input wire logic comm_err_in, // Internal comm error
    input wire logic [3:0] chan_cfg_err_in, // Per-channel config error
    input wire logic [3:0] chan_short_in, // Per-channel short/overload
    input wire logic [3:0] short_enable_in, // Short detection enables
    output logic [3:0] chan_led_out // Channel indicators
);
    logic [7:0] detail [aodr_pkg::NUM_CHAN];
    logic [3:0] chan_err;
    logic [3:0] chan_short_ok;
    logic [31:0] ticks;
    logic [7:0] general_error_flags;
    logic [7:0] second_error_flags;
    logic [7:0] channel_error_summary;
    logic [31:0] ticker_snap;
    logic [7:0] rec [aodr_pkg::REC_LEN];

    aodr_pkg::aodr_state_t state;
    logic [4:0] ptr;
    logic [4:0] last_ptr;
    logic bad;

    // Per-channel detail and indicator
    genvar gi;
    generate
        for (gi = 0; gi < aodr_pkg::NUM_CHAN; gi++) begin : g_chan
            aodr_chan_diag u_chan (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .cfg_err_in(chan_cfg_err_in[gi]),
                .short_in(chan_short_in[gi]),
                .short_en_in(short_enable_in[gi]),
                .detail_out(detail[gi]),
                .led_out(chan_led_out[gi])
            );
            assign chan_short_ok[gi] = chan_short_in[gi] & short_enable_in[gi];
            assign chan_err[gi] = chan_short_ok[gi] | chan_cfg_err_in[gi];
        end
    endgenerate

    aodr_us_ticker u_ticker (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ticks_out(ticks)
    );

    // Summary bytes, registered so they line up with the detail bytes
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            general_error_flags <= 8'h00;
            second_error_flags <= 8'h00;
            channel_error_summary <= 8'h00;
        end else begin
            general_error_flags <= 8'h00;
            general_error_flags[aodr_pkg::GEN_MODFAIL] <= module_fail_in;
            general_error_flags[aodr_pkg::GEN_INTERNAL] <= internal_err_in;
            general_error_flags[aodr_pkg::GEN_EXTERNAL] <= |chan_short_ok;
            general_error_flags[aodr_pkg::GEN_CHANNEL] <= |chan_err;
            general_error_flags[aodr_pkg::GEN_AUXSUP] <= aux_supply_missing_in;
            general_error_flags[aodr_pkg::GEN_PARAM] <= param_err_in | (|chan_cfg_err_in);
            second_error_flags <= 8'h00;
            second_error_flags[aodr_pkg::SEC_OVERFLOW] <= diag_overflow_in;
            second_error_flags[aodr_pkg::SEC_COMM] <= comm_err_in;
            channel_error_summary <= {4'h0, chan_err};
        end
    end

    // Record image
    assign rec[aodr_pkg::POS_GENERAL] = general_error_flags;
    assign rec[aodr_pkg::POS_MODINFO] = aodr_pkg::MODINFO_VAL;
    assign rec[aodr_pkg::POS_RSVD] = aodr_pkg::ZERO_BYTE;
    assign rec[aodr_pkg::POS_SECOND] = second_error_flags;
    assign rec[aodr_pkg::POS_KIND] = aodr_pkg::CHAN_KIND_AO;
    assign rec[aodr_pkg::POS_BITS] = aodr_pkg::DIAG_BITS_VAL;
    assign rec[aodr_pkg::POS_COUNT] = aodr_pkg::CHAN_COUNT_VAL;
    assign rec[aodr_pkg::POS_SUMMARY] = channel_error_summary;
    generate
        for (gi = 0; gi < aodr_pkg::NUM_CHAN; gi++) begin : g_detail
            assign rec[aodr_pkg::POS_DETAIL0 + gi] = detail[gi];
        end
        for (gi = 0; gi < aodr_pkg::NUM_UNUSED; gi++) begin : g_unused
            assign rec[aodr_pkg::POS_UNUSED0 + gi] = aodr_pkg::ZERO_BYTE;
        end
        // Ticker least significant byte first
        for (gi = 0; gi < aodr_pkg::TICK_BYTES; gi++) begin : g_tick
            assign rec[aodr_pkg::POS_TICK0 + gi] = ticker_snap[8 * gi +: 8];
        end
    endgenerate

    // Request decode
    logic take;
    logic is_rec;
    logic is_idx;
    logic is_sub;
    logic rec_full;
    logic rec_short;
    logic idx_full;
    logic idx_short;
    logic sub_byte;
    logic sub_tick;
    logic want_full;
    logic want_short;
    logic req_ok;
    logic [4:0] sub_pos;
    logic [4:0] next_start;
    logic [4:0] next_len;
    logic [4:0] next_last;
    logic at_last;

    assign take = req_valid_in & req_ready_out;
    assign is_rec = (req_path_in == aodr_pkg::PATH_RECORD);
    assign is_idx = (req_path_in == aodr_pkg::PATH_INDEX);
    assign is_sub = (req_path_in == aodr_pkg::PATH_SUBINDEX)
                    && (req_object_index_in == aodr_pkg::IDX_SUBOBJ);
    assign rec_full = is_rec && (req_record_number_in == aodr_pkg::RECNUM_FULL);
    assign rec_short = is_rec && (req_record_number_in == aodr_pkg::RECNUM_SHORT);
    assign idx_full = is_idx && (req_object_index_in == aodr_pkg::IDX_FULL);
    assign idx_short = is_idx && (req_object_index_in == aodr_pkg::IDX_SHORT);
    // Subindex 12h falls between the reserved bytes and the ticker: refused
    assign sub_byte = is_sub && (req_object_subindex_in >= aodr_pkg::SUB_FIRST)
                      && (req_object_subindex_in <= aodr_pkg::SUB_LAST_BYTE);
    assign sub_tick = is_sub && (req_object_subindex_in == aodr_pkg::SUB_TICKER);
    assign sub_pos = 5'(req_object_subindex_in - aodr_pkg::SUB_FIRST);
    assign want_full = rec_full | idx_full;
    assign want_short = rec_short | idx_short;
    assign req_ok = want_full | want_short | sub_byte | sub_tick;

    assign next_start = sub_byte ? sub_pos :
                        sub_tick ? aodr_pkg::POS_TICKER : aodr_pkg::POS_GENERAL;
    assign next_len = want_full ? aodr_pkg::LEN_FULL :
                      want_short ? aodr_pkg::LEN_SHORT :
                      sub_tick ? aodr_pkg::LEN_TICKER : aodr_pkg::LEN_BYTE;
    assign next_last = next_start + next_len - aodr_pkg::LEN_BYTE;
    assign at_last = bad | (ptr == last_ptr);

    // Reader: takes one request, streams its bytes on consecutive cycles.
    // Ticker is frozen at the request so its four bytes agree.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= aodr_pkg::ST_IDLE;
            ptr <= 5'h00;
            last_ptr <= 5'h00;
            bad <= 1'b0;
            ticker_snap <= 32'h0000_0000;
            req_ready_out <= 1'b1;
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 8'h00;
            rsp_last_out <= 1'b0;
            rsp_err_out <= 1'b0;
        end else begin
            unique case (state)
                aodr_pkg::ST_IDLE: begin
                    rsp_valid_out <= 1'b0;
                    rsp_last_out <= 1'b0;
                    rsp_err_out <= 1'b0;
                    rsp_data_out <= 8'h00;
                    if (take) begin
                        state <= aodr_pkg::ST_SEND;
                        req_ready_out <= 1'b0;
                        ptr <= next_start;
                        last_ptr <= next_last;
                        bad <= ~req_ok;
                        ticker_snap <= ticks;
                    end
                end
                aodr_pkg::ST_SEND: begin
                    rsp_valid_out <= 1'b1;
                    rsp_data_out <= bad ? aodr_pkg::ZERO_BYTE : rec[ptr];
                    rsp_last_out <= at_last;
                    rsp_err_out <= bad;
                    ptr <= ptr + 5'h01;
                    if (at_last) begin
                        state <= aodr_pkg::ST_IDLE;
                        req_ready_out <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : aodr_diag_record

// ===== aodr_pkg.sv
// Constants, record layout and access codes of the analog output diagnostic record.
// Assumes a single 200 MHz clock domain; used by the record, channel diagnostic and ticker files.
package aodr_pkg;

    // Access paths offered to the coupler
    typedef enum logic [1:0] {
        PATH_RECORD = 2'h0,
        PATH_INDEX = 2'h1,
        PATH_SUBINDEX = 2'h2
    } aodr_path_t;

    // Reader states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_SEND = 2'h2
    } aodr_state_t;

    // Record-set access
    localparam logic [7:0] RECNUM_FULL = 8'h01;
    localparam logic [7:0] RECNUM_SHORT = 8'h00;
    // Object-index access
    localparam logic [15:0] IDX_FULL = 16'h2f01;
    localparam logic [15:0] IDX_SHORT = 16'h2f00;
    localparam logic [15:0] IDX_SUBOBJ = 16'h5005;
    // Subindex access
    localparam logic [7:0] SUB_FIRST = 8'h02;
    localparam logic [7:0] SUB_LAST_BYTE = 8'h11;
    localparam logic [7:0] SUB_TICKER = 8'h13;

    // Record lengths and byte positions
    localparam int REC_LEN = 20;
    localparam logic [4:0] LEN_FULL = 5'h14;
    localparam logic [4:0] LEN_SHORT = 5'h04;
    localparam logic [4:0] LEN_BYTE = 5'h01;
    localparam logic [4:0] LEN_TICKER = 5'h04;
    localparam logic [4:0] POS_GENERAL = 5'h00;
    localparam logic [4:0] POS_TICKER = 5'h10;
    localparam int POS_MODINFO = 1;
    localparam int POS_RSVD = 2;
    localparam int POS_SECOND = 3;
    localparam int POS_KIND = 4;
    localparam int POS_BITS = 5;
    localparam int POS_COUNT = 6;
    localparam int POS_SUMMARY = 7;
    localparam int POS_DETAIL0 = 8;
    localparam int POS_UNUSED0 = 12;
    localparam int POS_TICK0 = 16;
    localparam int NUM_CHAN = 4;
    localparam int NUM_UNUSED = 4;
    localparam int TICK_BYTES = 4;

    // Constant bytes
    localparam logic [3:0] MOD_CLASS_ANALOG = 4'h5;
    localparam int MOD_CHINFO_BIT = 4;
    localparam logic [7:0] MODINFO_VAL = 8'h15;
    localparam logic [7:0] CHAN_KIND_AO = 8'h73;
    localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
    localparam logic [7:0] CHAN_COUNT_VAL = 8'h04;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // General error byte bits
    localparam int GEN_MODFAIL = 0;
    localparam int GEN_INTERNAL = 1;
    localparam int GEN_EXTERNAL = 2;
    localparam int GEN_CHANNEL = 3;
    localparam int GEN_AUXSUP = 4;
    localparam int GEN_PARAM = 7;
    // Second error byte bits
    localparam int SEC_OVERFLOW = 3;
    localparam int SEC_COMM = 4;
    // Channel detail byte bits
    localparam int DET_CFG = 0;
    localparam int DET_SHORT = 1;

    // Microsecond ticker timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] PRESCALE_LAST = 8'(TICK_CYCLES - 1);

endpackage : aodr_pkg

// ===== aodr_us_ticker.sv
// Free-running 32-bit microsecond ticker.
// Assumes clk_in at 200 MHz; wraps silently at full scale.
module aodr_us_ticker (
    input wire logic clk_in, // System clock
    input wire logic rst_b_in, // Async reset, active low
    output logic [31:0] ticks_out // Microseconds since reset
);
    logic [7:0] prescale;
    logic tick_now;

    assign tick_now = (prescale == aodr_pkg::PRESCALE_LAST);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prescale <= 8'h00;
            ticks_out <= 32'h0000_0000;
        end else begin
            prescale <= tick_now ? 8'h00 : prescale + 8'h01;
            if (tick_now) begin
                ticks_out <= ticks_out + 32'h0000_0001;
            end
        end
    end
endmodule : aodr_us_ticker

// ===== test_aodr_diag_record.sv
// Testbench of the diagnostic record: reads over all paths against computed bytes.
// Assumes the coupler model in aodr_coupler_model.sv and the checker file.
module test_aodr_diag_record;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [5:0] flags = 6'h0;
    logic [3:0] cfg = 4'h0, shrt = 4'h0, en = 4'h0, led;
    logic req_valid, ready, rsp_valid, rsp_last, rsp_err;
    logic [1:0] path;
    logic [7:0] rn, sx, rsp_data;
    logic [15:0] ix;
    logic [7:0] got [0:19];
    logic [31:0] t0;
    int cnt, c0, err_count = 0, total_checks = 0;

    aodr_diag_record aodr_diag_record_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid), .req_path_in(path), .req_record_number_in(rn),
        .req_object_index_in(ix), .req_object_subindex_in(sx), .req_ready_out(ready),
        .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_last_out(rsp_last),
        .rsp_err_out(rsp_err), .module_fail_in(flags[0]), .internal_err_in(flags[1]),
        .aux_supply_missing_in(flags[2]), .param_err_in(flags[3]),
        .diag_overflow_in(flags[4]), .comm_err_in(flags[5]), .chan_cfg_err_in(cfg),
        .chan_short_in(shrt), .short_enable_in(en), .chan_led_out(led));
    aodr_coupler_model aodr_coupler_model_i (.clk_in(clk_in), .ready_in(ready),
        .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data), .rsp_last_in(rsp_last),
        .rsp_err_in(rsp_err), .valid_out(req_valid), .path_out(path), .rn_out(rn),
        .ix_out(ix), .sx_out(sx));

    initial forever #2.5 clk_in = ~clk_in;

    function automatic logic [7:0] exp_byte(input int i);
        logic [3:0] bad;
        bad = cfg | (shrt & en);
        case (i)
            0: return {cfg != 4'h0 || flags[3], 2'h0, flags[2], bad != 4'h0,
                (shrt & en) != 4'h0, flags[1:0]};
            1: return 8'h15;
            3: return {3'h0, flags[5:4], 3'h0};
            4: return 8'h73;
            5: return 8'h08;
            6: return 8'h04;
            7: return {4'h0, bad};
            8, 9, 10, 11: return {6'h0, shrt[i-8] & en[i-8], cfg[i-8]};
            default: return 8'h00;
        endcase
    endfunction : exp_byte

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check8
    task automatic check_int(input string what, input int exp, input int seen);
        check8(what, 8'(exp), 8'(seen));
    endtask : check_int
    task automatic check_rng(input string what, input logic [31:0] lo, input logic [31:0] seen);
        check8(what, 8'h01, {7'h0, seen === lo || seen === lo + 32'h1});
    endtask : check_rng
    task automatic rd(input logic [1:0] p, input logic [7:0] r, input logic [15:0] x,
            input logic [7:0] s);
        aodr_coupler_model_i.rd(p, r, x, s);
        got = aodr_coupler_model_i.got;
        cnt = aodr_coupler_model_i.cnt;
    endtask : rd
    task automatic check_rec(input logic [1:0] p, input logic [7:0] r, input logic [15:0] x,
            input int n);
        rd(p, r, x, 8'h00);
        check_int("length", n, cnt);
        for (int k = 0; k < n && k < 16; k++)
            check8("rec byte", exp_byte(k), got[k]);
    endtask : check_rec
    task automatic check_bad(input logic [1:0] p, input logic [15:0] x, input logic [7:0] s);
        rd(p, 8'h02, x, s);
        check_int("refused length", 1, cnt);
        check8("refused flag", 8'h01, {7'h0, aodr_coupler_model_i.err});
    endtask : check_bad
    task automatic chan_case(input logic [3:0] c, input logic [3:0] s, input logic [3:0] e);
        @(posedge clk_in);
        #1;
        {cfg, shrt, en} = {c, s, e};
        check_rec(2'h0, 8'h01, 16'h0, 20);
        check8("indicators", {4'h0, c | (s & e)}, {4'h0, led});
    endtask : chan_case

    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        check_rec(2'h0, 8'h01, 16'h0, 20);
        for (int k = 16; k < 20; k++) check8("ticker at reset", 8'h00, got[k]);
        check_rec(2'h0, 8'h00, 16'h0, 4);
        check_rec(2'h1, 8'h00, 16'h2f01, 20);
        check_rec(2'h1, 8'h00, 16'h2f00, 4);
        for (int s = 2; s < 18; s++) begin
            rd(2'h2, 8'h00, 16'h5005, 8'(s));
            check_int("subindex length", 1, cnt);
            check8("sub byte", exp_byte(s - 2), got[0]);
        end
        check_bad(2'h0, 16'h0, 8'h00);
        check_bad(2'h1, 16'h2f02, 8'h00);
        check_bad(2'h3, 16'h2f01, 8'h02);
        check_bad(2'h2, 16'h2f01, 8'h02);
        check_bad(2'h2, 16'h5005, 8'h01);
        check_bad(2'h2, 16'h5005, 8'h12);
        check_bad(2'h2, 16'h5005, 8'h14);
        // Inputs move off the edge so the record never races the bench
        for (int b = 0; b < 6; b++) begin
            #1 flags = 6'(1 << b);
            check_rec(2'h0, 8'h01, 16'h0, 20);
        end
        #1 flags = 6'h0;
        chan_case(4'h2, 4'h0, 4'h0);
        chan_case(4'h0, 4'h4, 4'h0);
        chan_case(4'h0, 4'h4, 4'h4);
        chan_case(4'h9, 4'h6, 4'h3);
        rd(2'h2, 8'h00, 16'h5005, 8'h13);
        check_int("ticker length", 4, cnt);
        t0 = {got[3], got[2], got[1], got[0]};
        c0 = aodr_coupler_model_i.take_cyc;
        repeat (2000) @(posedge clk_in);
        rd(2'h2, 8'h00, 16'h5005, 8'h13);
        check_rng("ticker advance", 32'((aodr_coupler_model_i.take_cyc - c0) / 200),
            {got[3], got[2], got[1], got[0]} - t0);
        wrap_up();
    end
endmodule : test_aodr_diag_record

bind aodr_diag_record aodr_diag_checker aodr_diag_checker_i (.clk_in, .rst_b_in,
    .req_valid_in, .req_path_in, .req_record_number_in, .req_object_index_in,
    .req_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_last_out, .rsp_err_out,
    .chan_cfg_err_in, .chan_short_in, .short_enable_in, .chan_led_out);
